// ===== aio_adc_link_io.sv
`timescale 1ns/1ps
`include "aio_defines.svh"
// Behaviour
// - One measurement-complete pulse per conversion, driven inverted on its output.
// - External trigger is inverted, captured in a latch, status readable.
// - Software trigger clear resets the latch so the next one is caught.
// - Trigger-clear line doubles as calibration jumper input when sampled.
// - Each control bit is one pulse: 18 us for zero, 50 us for one.
// - After the bits a 200 us strobe pulse latches the word remotely.
// - Control pulses leave on two buffered output lines toward the isolator.
// - Each returning data pulse increments an 8-bit hardware counter.
// - After 256 pulses the counter overflow raises an internal event.
// - Each overflow decrements a separate software count, stopping at zero; counting continues.
module aio_adc_link_io #(
    parameter int MAX_BITS = 32,
    parameter int CYC_ZERO = `AIO_CYC_ZERO,
    parameter int CYC_ONE = `AIO_CYC_ONE,
    parameter int CYC_STROBE = `AIO_CYC_STROBE,
    parameter int CYC_GAP = `AIO_CYC_GAP
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic meas_done_port_out,
    input wire logic ext_trigger_in,
    input wire logic trigger_clear_jumper_line_in,
    output logic trigger_clear_jumper_line_out,
    output logic trigger_clear_jumper_line_oe,
    output logic conv_ctrl_out_a,
    output logic conv_ctrl_out_b,
    input wire logic conv_data_pulse
);

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave

    function automatic logic sel_reg(input logic [11:0] addr, input logic [11:0] off);
        sel_reg = (addr == off);
    endfunction

    aio_pkg::aio_ahb_req_s req;
    aio_pkg::aio_ahb_req_s ap;
    logic ap_valid;
    logic wr_ctrl;
    logic wr_tx;
    logic wr_sw;
    logic [31:0] ctrl;
    logic [31:0] tx_word;
    logic [15:0] sw_count;
    logic sw_zero;
    logic busy;
    logic trig_latch;
    logic jumper;
    logic ovf_flag;
    logic [7:0] hw_count;
    logic send_pulse;
    logic done_pulse;
    logic trig_clr_pulse;
    logic jump_sample_pulse;

    assign req = '{haddr: haddr, htrans: htrans, hwrite: hwrite, hsize: hsize, hsel: hsel};
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap <= '0;
            ap_valid <= 1'b0;
        end
        else if (hready)
        begin
            ap <= req;
            ap_valid <= hsel && htrans[1];
        end
    end

    assign wr_ctrl = ap_valid && ap.hwrite && sel_reg(ap.haddr[11:0], `AIO_OFF_CTRL);
    assign wr_tx = ap_valid && ap.hwrite && sel_reg(ap.haddr[11:0], `AIO_OFF_TXDATA);
    assign wr_sw = ap_valid && ap.hwrite && sel_reg(ap.haddr[11:0], `AIO_OFF_SWCOUNT);

    // Command bits in CTRL self-clear: send, done and trigger clear act for one cycle per write; the jumper-sample bit holds until the next CTRL write
    assign send_pulse = wr_ctrl && hwdata[`AIO_CTRL_SEND] && !busy;
    assign done_pulse = wr_ctrl && hwdata[`AIO_CTRL_DONE];
    assign trig_clr_pulse = wr_ctrl && hwdata[`AIO_CTRL_TRIG_CLR];
    assign jump_sample_pulse = wr_ctrl && hwdata[`AIO_CTRL_JUMPER_SAMPLE];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctrl <= `AIO_RESET_WORD;
        else if (wr_ctrl)
            ctrl <= {18'h00000, hwdata[`AIO_CTRL_LEN_MSB:`AIO_CTRL_LEN_LSB], 3'h0,
                     hwdata[`AIO_CTRL_CNT_EN], 4'h0};
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            tx_word <= `AIO_RESET_WORD;
        else if (wr_tx && !busy)
            tx_word <= hwdata;
    end

    // Read data registered in the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (hready && hsel && htrans[1] && !hwrite)
        begin
            case (haddr[11:0])
                `AIO_OFF_CTRL: hrdata <= ctrl;
                `AIO_OFF_TXDATA: hrdata <= tx_word;
                `AIO_OFF_STATUS: hrdata <= {27'h0000000, sw_zero, ovf_flag, jumper,
                                            trig_latch, busy};
                `AIO_OFF_COUNT: hrdata <= {24'h000000, hw_count};
                `AIO_OFF_SWCOUNT: hrdata <= {16'h0000, sw_count};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Measurement complete output

    logic [$clog2(`AIO_CYC_DONE + 1)-1:0] done_cnt;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            done_cnt <= '0;
        else if (done_pulse)
            done_cnt <= ($clog2(`AIO_CYC_DONE + 1))'(`AIO_CYC_DONE);
        else if (done_cnt != '0)
            done_cnt <= done_cnt - 1'b1;
    end

    // Inverting buffer: idle high, low during the pulse
    assign meas_done_port_out = (done_cnt == '0);

    ////////////////////////////////////////////////////////////////////////////
    // Trigger latch and jumper sampling

    logic trig_prev;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            trig_prev <= 1'b0;
        else
            trig_prev <= !ext_trigger_in;
    end

    // Inverted input falling means a trigger edge; capture wins over clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            trig_latch <= 1'b0;
        else if (trig_prev && ext_trigger_in)
            trig_latch <= 1'b1;
        else if (trig_clr_pulse)
            trig_latch <= 1'b0;
    end

    // Line is released while sampling so the jumper sets its level
    logic jumper_mode;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            jumper_mode <= 1'b0;
        else if (wr_ctrl)
            jumper_mode <= hwdata[`AIO_CTRL_JUMPER_SAMPLE];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            jumper <= 1'b0;
        else if (jumper_mode && !jump_sample_pulse)
            jumper <= trigger_clear_jumper_line_in;
    end

    assign trigger_clear_jumper_line_oe = !jumper_mode;

    // Registered so the pin pulse is one clean cycle wide
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            trigger_clear_jumper_line_out <= 1'b0;
        else
            trigger_clear_jumper_line_out <= trig_clr_pulse;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control link transmitter

    aio_pkg::aio_link_e state;
    aio_pkg::aio_link_s link;
    logic [$clog2(MAX_BITS+1)-1:0] bits_left;
    logic [$clog2(MAX_BITS)-1:0] bit_idx;
    logic [15:0] tcnt;
    logic [5:0] nbits;

    // A start takes the length written with it, not the one stored before
    assign nbits = wr_ctrl ? hwdata[`AIO_CTRL_LEN_MSB:`AIO_CTRL_LEN_LSB]
                           : ctrl[`AIO_CTRL_LEN_MSB:`AIO_CTRL_LEN_LSB];
    assign busy = (state != aio_pkg::AIO_IDLE);

    function automatic logic [15:0] bit_width(input logic b);
        bit_width = b ? 16'(CYC_ONE) : 16'(CYC_ZERO);
    endfunction

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= aio_pkg::AIO_IDLE;
            tcnt <= 16'h0000;
            bits_left <= '0;
            bit_idx <= '0;
        end
        else
        begin
            case (state)
                aio_pkg::AIO_IDLE:
                begin
                    if (send_pulse)
                    begin
                        bit_idx <= '0;
                        if (nbits == 6'h00)
                        begin
                            state <= aio_pkg::AIO_STROBE;
                            tcnt <= 16'(CYC_STROBE - 1);
                        end
                        else
                        begin
                            state <= aio_pkg::AIO_PULSE;
                            bits_left <= ($clog2(MAX_BITS+1))'(nbits);
                            tcnt <= bit_width(tx_word[0]) - 16'h0001;
                        end
                    end
                end
                aio_pkg::AIO_PULSE:
                begin
                    if (tcnt == 16'h0000)
                    begin
                        state <= aio_pkg::AIO_GAP;
                        tcnt <= 16'(CYC_GAP - 1);
                        bits_left <= bits_left - 1'b1;
                    end
                    else
                        tcnt <= tcnt - 16'h0001;
                end
                aio_pkg::AIO_GAP:
                begin
                    if (tcnt != 16'h0000)
                        tcnt <= tcnt - 16'h0001;
                    else if (bits_left == '0)
                    begin
                        state <= aio_pkg::AIO_STROBE;
                        tcnt <= 16'(CYC_STROBE - 1);
                    end
                    else
                    begin
                        state <= aio_pkg::AIO_PULSE;
                        bit_idx <= bit_idx + 1'b1;
                        tcnt <= bit_width(tx_word[bit_idx + 1'b1]) - 16'h0001;
                    end
                end
                aio_pkg::AIO_STROBE:
                begin
                    if (tcnt == 16'h0000)
                        state <= aio_pkg::AIO_IDLE;
                    else
                        tcnt <= tcnt - 16'h0001;
                end
                default: state <= aio_pkg::AIO_IDLE;
            endcase
        end
    end

    // Both lines carry the same pulse train, registered for glitch-free edges
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            link <= '0;
        else
        begin
            link.ctrl_a <= (state == aio_pkg::AIO_PULSE) || (state == aio_pkg::AIO_STROBE);
            link.ctrl_b <= (state == aio_pkg::AIO_PULSE) || (state == aio_pkg::AIO_STROBE);
        end
    end

    assign conv_ctrl_out_a = link.ctrl_a;
    assign conv_ctrl_out_b = link.ctrl_b;

    ////////////////////////////////////////////////////////////////////////////
    // Returning data pulse counter

    logic data_prev;
    logic data_edge;
    logic wrap;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            data_prev <= 1'b0;
        else
            data_prev <= conv_data_pulse;
    end

    assign data_edge = conv_data_pulse && !data_prev && ctrl[`AIO_CTRL_CNT_EN];
    assign wrap = data_edge && (hw_count == 8'hFF);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hw_count <= 8'h00;
        else if (data_edge)
            hw_count <= hw_count + 8'h01;
    end

    // Overflow flag is cleared by a trigger clear or a SWCOUNT write; set wins
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ovf_flag <= 1'b0;
        else if (wrap)
            ovf_flag <= 1'b1;
        else if (trig_clr_pulse || wr_sw)
            ovf_flag <= 1'b0;
    end

    // Software count steps down in hardware on each wrap, saturating at zero
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            sw_count <= 16'h0000;
        else if (wrap && sw_count != 16'h0000)
            sw_count <= sw_count - 16'h0001;
        else if (wr_sw)
            sw_count <= hwdata[15:0];
    end

    assign sw_zero = (sw_count == 16'h0000);

endmodule

// ===== aio_defines.svh
`ifndef AIO_DEFINES_SVH
`define AIO_DEFINES_SVH

// Register byte offsets
`define AIO_OFF_CTRL 12'h000
`define AIO_OFF_TXDATA 12'h004
`define AIO_OFF_STATUS 12'h008
`define AIO_OFF_COUNT 12'h00C
`define AIO_OFF_SWCOUNT 12'h010

// CTRL fields
`define AIO_CTRL_SEND 0
`define AIO_CTRL_DONE 1
`define AIO_CTRL_TRIG_CLR 2
`define AIO_CTRL_JUMPER_SAMPLE 3
`define AIO_CTRL_CNT_EN 4
`define AIO_CTRL_LEN_LSB 8
`define AIO_CTRL_LEN_MSB 13

// STATUS fields
`define AIO_ST_BUSY 0
`define AIO_ST_TRIG 1
`define AIO_ST_JUMPER 2
`define AIO_ST_OVF 3
`define AIO_ST_SW_ZERO 4

// Timing, microseconds and derived cycles at 50 MHz
`define AIO_CLK_MHZ 50
`define AIO_T_ZERO_US 18
`define AIO_T_ONE_US 50
`define AIO_T_STROBE_US 200
`define AIO_T_GAP_US 18
`define AIO_CYC_ZERO (`AIO_T_ZERO_US * `AIO_CLK_MHZ)
`define AIO_CYC_ONE (`AIO_T_ONE_US * `AIO_CLK_MHZ)
`define AIO_CYC_STROBE (`AIO_T_STROBE_US * `AIO_CLK_MHZ)
`define AIO_CYC_GAP (`AIO_T_GAP_US * `AIO_CLK_MHZ)
`define AIO_CYC_DONE 50

`define AIO_RESET_WORD 32'h0000_0000

`endif

// ===== aio_pkg.sv
package aio_pkg;

typedef enum logic [1:0] {
    AIO_IDLE,
    AIO_PULSE,
    AIO_GAP,
    AIO_STROBE
} aio_link_e;

typedef struct packed {
    logic ctrl_a;
    logic ctrl_b;
} aio_link_s;

typedef struct packed {
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hsel;
} aio_ahb_req_s;

endpackage

// ===== aio_adc_link_io_assertions.sv
`timescale 1ns/1ps
module aio_adc_link_io_assertions #(
    parameter int MAX_BITS = 32,
    parameter int CYC_ZERO = 900,
    parameter int CYC_ONE = 2500,
    parameter int CYC_STROBE = 10000,
    parameter int CYC_GAP = 900
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic meas_done_port_out,
    input wire logic ext_trigger_in,
    input wire logic trigger_clear_jumper_line_in,
    input wire logic trigger_clear_jumper_line_out,
    input wire logic trigger_clear_jumper_line_oe,
    input wire logic conv_ctrl_out_a,
    input wire logic conv_ctrl_out_b,
    input wire logic conv_data_pulse
);
    int hi_run;
    int lo_run;
    logic wr_ctrl;
    assign wr_ctrl = hsel && hready && htrans[1] && hwrite && haddr[11:0] == 12'h000;
    ////////////////////////////////////////////////////////////////////////////////
    // Run lengths let one check cover every width without long repetitions
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hi_run <= 0;
            lo_run <= 0;
        end
        else
        begin
            hi_run <= conv_ctrl_out_a ? hi_run + 1 : 0;
            lo_run <= conv_ctrl_out_a ? 0 : lo_run + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    AST_OKAY: assert property (hresp == 1'b0 && hreadyout == 1'b1)
        else $error("bus answer not ready or not okay");
    AST_LINES_SAME: assert property (conv_ctrl_out_a == conv_ctrl_out_b)
        else $error("control lines differ");
    AST_PULSE_WIDTH: assert property ((hi_run != 0 && !conv_ctrl_out_a) |->
        (hi_run == CYC_ZERO || hi_run == CYC_ONE || hi_run == CYC_STROBE))
        else $error("control pulse width not a legal code");
    AST_PULSE_CAP: assert property (hi_run <= CYC_STROBE)
        else $error("control pulse longer than strobe");
    AST_GAP: assert property ((lo_run != 0 && conv_ctrl_out_a) |-> lo_run >= CYC_GAP)
        else $error("gap between pulses too short");
    AST_DONE_START: assert property (wr_ctrl ##1 hwdata[1] |=> !meas_done_port_out)
        else $error("done pulse did not start");
    AST_DONE_WIDTH: assert property ($fell(meas_done_port_out) |->
        ##49 !meas_done_port_out ##1 meas_done_port_out)
        else $error("done pulse width wrong");
    AST_CLEAR_PULSE: assert property (wr_ctrl ##1 (hwdata[2] && !hwdata[3]) |=>
        trigger_clear_jumper_line_out && trigger_clear_jumper_line_oe
        ##1 !trigger_clear_jumper_line_out)
        else $error("trigger clear pulse wrong");
    AST_JUMPER_OE: assert property (wr_ctrl ##1 hwdata[3] |=> !trigger_clear_jumper_line_oe)
        else $error("shared line still driven in jumper mode");
    cover property (hi_run == CYC_STROBE);
    cover property ($fell(meas_done_port_out));
    cover property ($rose(trigger_clear_jumper_line_out));
endmodule

// ===== aio_conv_model.sv
`timescale 1ns/1ps
module aio_conv_model #(
    parameter int CYC_ZERO = 900,
    parameter int CYC_ONE = 2500,
    parameter int CYC_STROBE = 10000
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic conv_ctrl_out_a,
    input wire logic conv_ctrl_out_b,
    input wire logic [15:0] burst_n,
    input wire logic burst_go,
    output logic conv_data_pulse,
    output logic [31:0] word,
    output logic [7:0] bits,
    output logic [7:0] strobes
);
    int width;
    int nb;
    int left;
    logic [31:0] shreg;
    logic count_gate_phase;
    ////////////////////////////////////////////////////////////////////////////////
    // Midpoint thresholds tolerate isolator edge skew on either side
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            width <= 0;
            nb <= 0;
            shreg <= 32'h0;
            word <= 32'h0;
            bits <= 8'h0;
            strobes <= 8'h0;
        end
        else if (conv_ctrl_out_a && conv_ctrl_out_b)
            width <= width + 1;
        else if (width != 0)
        begin
            width <= 0;
            if (width > (CYC_ONE + CYC_STROBE) / 2)
            begin
                word <= shreg;
                bits <= 8'(nb);
                strobes <= strobes + 8'h01;
                shreg <= 32'h0;
                nb <= 0;
            end
            else
            begin
                shreg[nb] <= (width > (CYC_ZERO + CYC_ONE) / 2);
                nb <= nb + 1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            left <= 0;
            count_gate_phase <= 1'b0;
            conv_data_pulse <= 1'b0;
        end
        else if (burst_go)
            left <= int'(burst_n);
        else if (left != 0)
        begin
            count_gate_phase <= ~count_gate_phase;
            conv_data_pulse <= ~count_gate_phase;
            if (!count_gate_phase)
                left <= left - 1;
        end
        else
        begin
            count_gate_phase <= 1'b0;
            conv_data_pulse <= 1'b0;
        end
    end
endmodule

// ===== tb_aio_adc_link_io.sv
`timescale 1ns/1ps
`include "aio_defines.svh"
module tb_aio_adc_link_io;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready, hreadyout, hresp, done_n, line_in, line_out, line_oe, ctrl_a, ctrl_b, dpulse;
    logic [31:0] hrdata, rd, tx, rnd, m_word;
    logic ext_trig = 1'b1;
    logic jumper_lvl = 1'b0;
    logic [15:0] burst_n = 16'h0;
    logic burst_go = 1'b0;
    logic [7:0] m_bits, m_strobes;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;
    int k, n, len, nstr, total, exp_cnt, exp_sw;
    localparam int T_ZERO = 3;
    localparam int T_ONE = 8;
    localparam int T_STROBE = 20;
    localparam int T_GAP = 3;
    always #10 hclk = ~hclk;
    assign hready = hreadyout;
    assign line_in = line_oe ? line_out : jumper_lvl;
    aio_adc_link_io #(.CYC_ZERO(T_ZERO), .CYC_ONE(T_ONE), .CYC_STROBE(T_STROBE),
        .CYC_GAP(T_GAP)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .meas_done_port_out(done_n),
        .ext_trigger_in(ext_trig), .trigger_clear_jumper_line_in(line_in),
        .trigger_clear_jumper_line_out(line_out), .trigger_clear_jumper_line_oe(line_oe),
        .conv_ctrl_out_a(ctrl_a), .conv_ctrl_out_b(ctrl_b), .conv_data_pulse(dpulse));
    aio_conv_model #(.CYC_ZERO(T_ZERO), .CYC_ONE(T_ONE), .CYC_STROBE(T_STROBE)) u_conv (
        .hclk(hclk), .hresetn(hresetn), .conv_ctrl_out_a(ctrl_a), .conv_ctrl_out_b(ctrl_b),
        .burst_n(burst_n), .burst_go(burst_go), .conv_data_pulse(dpulse), .word(m_word),
        .bits(m_bits), .strobes(m_strobes));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
            err_total++;
        end
    endtask
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask
    // Busy is polled rather than timed so the bench assumes no pulse timing
    task automatic wait_idle();
        for (int i = 0; i < 500; i++)
        begin
            ahb(1'b0, `AIO_OFF_STATUS, 32'h0);
            if (rd[0] === 1'b0)
                break;
        end
        chk({31'h0, rd[0]}, 32'h0);
        repeat (2) @(posedge hclk);
    endtask
    task automatic give_verdict();
        $display("TB counts: %0d compares, %0d mismatches", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            err_total++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rnd = 32'h0535;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk(`AIO_OFF_STATUS, 32'h1F, 32'h10);
        ahb(1'b1, 12'h020, 32'hFFFF_FFFF);
        rdchk(12'h020, 32'hFFFF_FFFF, 32'h0);
        $display("TB test done: unmapped");
        for (k = 0; k < 4; k++)
        begin
            rnd = lfsr(rnd);
            len = (k < 2) ? 1 : (k == 2 ? 32 : 7);
            tx = (k == 0) ? 32'h1 : rnd;
            nstr = int'(m_strobes);
            ahb(1'b1, `AIO_OFF_TXDATA, tx);
            ahb(1'b1, `AIO_OFF_CTRL, 32'h0000_0011 | (32'(len) << 8));
            if (k == 3)
            begin
                // Busy must refuse both a new word and a second start
                ahb(1'b1, `AIO_OFF_TXDATA, ~tx);
                ahb(1'b1, `AIO_OFF_CTRL, 32'h0000_0011 | (32'(len) << 8));
            end
            wait_idle();
            chk(m_word, (len == 32) ? tx : tx & ((32'h1 << len) - 32'h1));
            chk({24'h0, m_bits}, 32'(len));
            chk({24'h0, m_strobes}, 32'(nstr + 1));
        end
        $display("TB test done: control link");
        ahb(1'b1, `AIO_OFF_CTRL, 32'h0000_0012);
        @(posedge hclk);
        chk({31'h0, done_n}, 32'h0);
        repeat (60) @(posedge hclk);
        chk({31'h0, done_n}, 32'h1);
        $display("TB test done: done pulse");
        for (k = 0; k < 2; k++)
        begin
            ext_trig <= 1'b0;
            repeat (2) @(posedge hclk);
            ext_trig <= 1'b1;
            @(posedge hclk);
            rdchk(`AIO_OFF_STATUS, 32'h2, 32'h2);
            ahb(1'b1, `AIO_OFF_CTRL, 32'h0000_0014);
            rdchk(`AIO_OFF_STATUS, 32'h2, 32'h0);
        end
        $display("TB test done: trigger");
        for (k = 0; k < 2; k++)
        begin
            jumper_lvl <= k[0];
            ahb(1'b1, `AIO_OFF_CTRL, 32'h0000_0018);
            rdchk(`AIO_OFF_STATUS, 32'h4, 32'(k) << 2);
        end
        ahb(1'b1, `AIO_OFF_CTRL, 32'h0000_0010);
        $display("TB test done: jumper");
        exp_cnt = 0;
        exp_sw = 2;
        ahb(1'b1, `AIO_OFF_SWCOUNT, 32'h2);
        for (k = 0; k < 3; k++)
        begin
            rnd = lfsr(rnd);
            n = (k == 0) ? 255 : (k == 1 ? 1 : 256 + int'(rnd[7:0]));
            burst_n <= 16'(n);
            burst_go <= 1'b1;
            @(posedge hclk);
            burst_go <= 1'b0;
            repeat (2 * n + 4) @(posedge hclk);
            total = exp_cnt + n;
            exp_sw = (exp_sw > total / 256) ? exp_sw - total / 256 : 0;
            exp_cnt = total % 256;
            rdchk(`AIO_OFF_COUNT, 32'hFF, 32'(exp_cnt));
            rdchk(`AIO_OFF_SWCOUNT, 32'hFFFF, 32'(exp_sw));
            rdchk(`AIO_OFF_STATUS, 32'h18,
                  (k > 0 ? 32'h8 : 32'h0) | (exp_sw == 0 ? 32'h10 : 32'h0));
        end
        $display("TB test done: pulse counter");
        give_verdict();
    end
endmodule
bind aio_adc_link_io aio_adc_link_io_assertions #(.MAX_BITS(MAX_BITS), .CYC_ZERO(CYC_ZERO),
    .CYC_ONE(CYC_ONE), .CYC_STROBE(CYC_STROBE), .CYC_GAP(CYC_GAP)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .meas_done_port_out(meas_done_port_out),
    .ext_trigger_in(ext_trigger_in),
    .trigger_clear_jumper_line_in(trigger_clear_jumper_line_in),
    .trigger_clear_jumper_line_out(trigger_clear_jumper_line_out),
    .trigger_clear_jumper_line_oe(trigger_clear_jumper_line_oe),
    .conv_ctrl_out_a(conv_ctrl_out_a), .conv_ctrl_out_b(conv_ctrl_out_b),
    .conv_data_pulse(conv_data_pulse));
